// ---- verilog/lpb_pkg.sv ----
package lpb_pkg;

  // Register addresses on the register port
  localparam logic [7:0] LPB_ADDR_PHASE_ZERO = 8'h02;
  localparam logic [7:0] LPB_ADDR_PHASE_ONE = 8'h0a;

  // Phase registers wake with every port released
  localparam logic [7:0] LPB_PHASE_RESET = 8'hff;
  localparam logic [7:0] LPB_RDATA_RESET = 8'h00;
  localparam logic [8:0] LPB_OE_N_RESET = 9'h1ff;

  // Intensity nibble coding
  localparam logic [3:0] LPB_NIBBLE_FULL = 4'hf;
  localparam logic [3:0] LPB_MASTER_OFF = 4'h0;

  // PWM frame: 15 master timeslots of 16 cycles each
  localparam logic [3:0] LPB_CYC_LAST = 4'hf;
  localparam logic [3:0] LPB_SLOT_LAST = 4'he;
  localparam logic [3:0] LPB_CNT_RESET = 4'h0;

  // PWM oscillator derived from the system clock
  localparam int LPB_MCLK_HZ = 20_000_000;
  localparam int LPB_OSC_HZ = 32_000;
  localparam int LPB_OSC_DIV = LPB_MCLK_HZ / LPB_OSC_HZ;
  localparam int LPB_DIV_W = 10;
  localparam logic [LPB_DIV_W-1:0] LPB_DIV_LAST =
    LPB_DIV_W'(LPB_OSC_DIV - 1);
  localparam logic [LPB_DIV_W-1:0] LPB_DIV_RESET = 10'h000;

endpackage

// ---- verilog/lpb_led_pwm_blink.sv ----
`timescale 1ns/1ps
// Function
// - Blink off: phase-zero register drives outputs
// - Blink on: flip XOR pin picks phase
// - Period is 15 slots of 16 cycles
// - Master nibble gates 1 to 15 slots
// - Individual nibble below 15 acts only in gated slots
// - Setting 16/16 gives static phase level
// - Phase bit sets which duty end reached
// - Phase-zero register at 0x02, read/write
// - Phase-one register at 0x0A, read/write
// - Ninth nibble doubles as global setting
// - Global mode applies master+ninth to all
// - Global mode covers every output or none
// - Master nibble zero makes everything static
// - Global mode ignores individual intensity inputs
// - Bit one releases port, zero pulls low
// - PWM oscillator stops when PWM disabled
// - Reads return stored register, not pins
module lpb_led_pwm_blink
  import lpb_pkg::*;
#(
  // Last divider count; one PWM cycle lasts this plus one clocks
  parameter logic [LPB_DIV_W-1:0] OSC_DIV_LAST = LPB_DIV_LAST
)
(
  input wire logic mclk, // System clock, 20 MHz
  input wire logic rst_n, // Asynchronous reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [7:0] reg_rdata, // Read data, next cycle
  input wire logic blink_en, // Blink enable flag
  input wire logic blink_flip, // Blink flip flag
  input wire logic blink_pin, // Blink input pin level
  input wire logic global_en, // Global intensity flag
  input wire logic ninth_phase_zero, // Ninth output, phase 0
  input wire logic ninth_phase_one, // Ninth output, phase 1
  input wire logic [7:0] master_ninth_intensity, // Master hi, ninth lo
  input wire logic [31:0] indiv_intensity, // Port n in bits 4n+3:4n
  input wire logic [7:0] general_ports_in, // Pin levels, not used here
  output logic [7:0] general_ports_out, // Pin drive value, always 0
  output logic [7:0] general_ports_oe_n, // Low pulls the pin low
  output logic interrupt_or_ninth_output_out, // Drive value, 0
  output logic interrupt_or_ninth_output_oe_n // Low pulls pin low
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] phase0;
    logic [7:0] phase1;
    logic [LPB_DIV_W-1:0] div;
    logic [3:0] cyc;
    logic [3:0] slot;
    logic [7:0] rdata;
    logic [8:0] oe_n;
  } lpb_state_t;

  lpb_state_t q;
  lpb_state_t d;

  logic [3:0] master_nib;
  logic [3:0] ninth_nib;
  logic pwm_on;
  logic tick;
  logic use_phase_one;
  logic gated;
  logic [8:0] sel_lvl;
  logic [8:0] lvl_d;

  ////////////////////////////////////////////////////////////////////
  // Per-output level decision

  // Full setting bypasses gating so a static output never glitches
  function automatic logic lpb_out_level(
    input logic lvl,
    input logic [3:0] n,
    input logic gate,
    input logic [3:0] cyc,
    input logic pwm
  );
    logic r;
    r = ~lvl; // Off-time holds the opposite level, also ungated
    if (!pwm || n == LPB_NIBBLE_FULL)
    begin
      r = lvl;
    end
    else if (gate && cyc <= n)
    begin
      r = lvl;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Phase selection and PWM gating

  assign master_nib = master_ninth_intensity[7:4];
  assign ninth_nib = master_ninth_intensity[3:0];
  // Master nibble zero turns the PWM off entirely
  assign pwm_on = (master_nib != LPB_MASTER_OFF);
  assign tick = pwm_on && (q.div == OSC_DIV_LAST);
  assign use_phase_one = blink_en && (blink_flip ^ blink_pin);
  // Slots 0..m-1 are gated, so m slots of 15 per period
  assign gated = (q.slot < master_nib);
  assign sel_lvl = use_phase_one ? {ninth_phase_one, q.phase1}
                                 : {ninth_phase_zero, q.phase0};

  // Global mode swaps every nibble for the ninth one, all or none
  always_comb
  begin
    logic [3:0] n;
    n = ninth_nib;
    lvl_d = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (global_en)
      begin
        n = ninth_nib;
      end
      else
      begin
        n = indiv_intensity[4*i +: 4];
      end
      lvl_d[i] = lpb_out_level(sel_lvl[i], n, gated, q.cyc, pwm_on);
    end
    // Ninth output always runs on its own nibble, global or not
    lvl_d[8] = lpb_out_level(sel_lvl[8], ninth_nib, gated, q.cyc, pwm_on);
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    // Oscillator and counters rest at zero while PWM is off
    if (!pwm_on)
    begin
      d.div = LPB_DIV_RESET;
      d.cyc = LPB_CNT_RESET;
      d.slot = LPB_CNT_RESET;
    end
    else if (tick)
    begin
      d.div = LPB_DIV_RESET;
      if (q.cyc == LPB_CYC_LAST)
      begin
        d.cyc = LPB_CNT_RESET;
        if (q.slot == LPB_SLOT_LAST)
        begin
          d.slot = LPB_CNT_RESET;
        end
        else
        begin
          d.slot = q.slot + 4'h1;
        end
      end
      else
      begin
        d.cyc = q.cyc + 4'h1;
      end
    end
    else
    begin
      d.div = q.div + 10'h001;
    end
    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == LPB_ADDR_PHASE_ZERO)
      begin
        d.phase0 = reg_wdata;
      end
      else if (reg_addr == LPB_ADDR_PHASE_ONE)
      begin
        d.phase1 = reg_wdata;
      end
    end
    // Reads show stored bits; pins may sit at any level
    if (reg_rd)
    begin
      if (reg_addr == LPB_ADDR_PHASE_ZERO)
      begin
        d.rdata = q.phase0;
      end
      else if (reg_addr == LPB_ADDR_PHASE_ONE)
      begin
        d.rdata = q.phase1;
      end
      else
      begin
        d.rdata = LPB_RDATA_RESET;
      end
    end
    // Level one releases the pin, zero sinks current
    d.oe_n = lvl_d;
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.phase0 <= LPB_PHASE_RESET;
      q.phase1 <= LPB_PHASE_RESET;
      q.div <= LPB_DIV_RESET;
      q.cyc <= LPB_CNT_RESET;
      q.slot <= LPB_CNT_RESET;
      q.rdata <= LPB_RDATA_RESET;
      q.oe_n <= LPB_OE_N_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: the drive value is always low, enable does the work
  assign general_ports_out = 8'h00;
  assign general_ports_oe_n = q.oe_n[7:0];
  assign interrupt_or_ninth_output_out = 1'b0;
  assign interrupt_or_ninth_output_oe_n = q.oe_n[8];
  assign reg_rdata = q.rdata;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  chk_blink_off_phase0: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!blink_en && !pwm_on) |=> (general_ports_oe_n == $past(q.phase0)))
  else $error("blink off did not use phase zero");

  chk_blink_on_select: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (blink_en && (blink_flip ^ blink_pin) && !pwm_on)
    |=> (general_ports_oe_n == $past(q.phase1)))
  else $error("blink on did not use phase one");

  chk_period_wrap: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (tick && q.cyc == 4'hf && q.slot == 4'he)
    |=> (q.cyc == 4'h0 && q.slot == 4'h0))
  else $error("pwm period did not wrap after 240 steps");

  chk_ungated_off: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pwm_on && !global_en && q.slot >= master_nib
     && indiv_intensity[3:0] != 4'hf)
    |=> (general_ports_oe_n[0] == !$past(sel_lvl[0])))
  else $error("ungated slot did not hold off level");

  chk_gated_on: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pwm_on && !global_en && q.slot < master_nib
     && q.cyc <= indiv_intensity[3:0])
    |=> (general_ports_oe_n[0] == $past(sel_lvl[0])))
  else $error("gated on time lost phase level");

  chk_full_static: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pwm_on && !global_en && indiv_intensity[7:4] == 4'hf)
    |=> (general_ports_oe_n[1] == $past(sel_lvl[1])))
  else $error("full setting was not static");

  chk_global_all: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pwm_on && global_en && ninth_nib == 4'hf)
    |=> (q.oe_n == $past(sel_lvl)))
  else $error("global full setting not applied to all");

  chk_osc_stop: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !pwm_on |=> (q.div == 10'h000 && q.slot == 4'h0))
  else $error("pwm oscillator ran while disabled");

  chk_read_stored: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h0a) |=> (reg_rdata == $past(q.phase1)))
  else $error("phase one read did not return stored value");

  chk_write_lands: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h02) |=> (q.phase0 == $past(reg_wdata)))
  else $error("phase zero write did not land");

  chk_gated_off_time: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pwm_on && !global_en && q.slot < master_nib
     && q.cyc > indiv_intensity[3:0])
    |=> (general_ports_oe_n[0] == !$past(sel_lvl[0])))
  else $error("gated off time kept phase level");

  chk_global_pwm: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (pwm_on && global_en && q.slot < master_nib && q.cyc > ninth_nib)
    |=> (q.oe_n == ~$past(sel_lvl)))
  else $error("global off time not applied to all");

endmodule

// ---- testbench/lpb_led_load.sv ----
`timescale 1ns/1ps
// Open-drain loads with pull-ups on all nine outputs
module lpb_led_load
(
  input wire logic [8:0] oe_n, // Low pulls the pin low
  output logic [8:0] pin // Wire level at the loads
);
  // Pull-up wins once the driver lets go, so no stale level
  assign pin = oe_n;
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import lpb_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, mni = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, blink_en = 1'b0, blink_flip = 1'b0;
  logic blink_pin = 1'b0, global_en = 1'b0, n0 = 1'b1, n1 = 1'b1;
  logic [31:0] ind = 32'h0;
  logic [7:0] rdata, pout, oe_n;
  logic n_oe_n, n_out;
  logic [8:0] pin;
  int miscompares = 0, n_checks = 0;
  ////////////////////////////////////////
  // Free-running 20 MHz clock
  always #25 mclk = ~mclk;
  // Short divider so whole 240-step frames fit in the run
  localparam int DIV = 10;
  lpb_led_pwm_blink #(.OSC_DIV_LAST(10'(DIV - 1))) dut (.mclk(mclk),
    .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .blink_en(blink_en), .blink_flip(blink_flip),
    .blink_pin(blink_pin), .global_en(global_en), .ninth_phase_zero(n0),
    .ninth_phase_one(n1), .master_ninth_intensity(mni),
    .indiv_intensity(ind), .general_ports_in(pin[7:0]),
    .general_ports_out(pout), .general_ports_oe_n(oe_n),
    .interrupt_or_ninth_output_out(n_out),
    .interrupt_or_ninth_output_oe_n(n_oe_n));
  lpb_led_load load (.oe_n({n_oe_n, oe_n}), .pin(pin));
  ////////////////////////////////////////
  // Inputs always move 5 ns after the rising edge
  task automatic tick();
    @(posedge mclk);
    #5;
  endtask
  task automatic cmp(string what, logic [8:0] seen, logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick(); // Idle edge keeps back-to-back strobes apart
  endtask
  // Read data is registered, so it is settled once tick returns
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    d = rdata;
    tick(); // Idle edge keeps back-to-back strobes apart
  endtask
  // Pin level for phase bit p, nibble n, master m at PWM step c
  function automatic logic lvl(logic p, logic [3:0] n, logic [3:0] m,
                               int c);
    if (m == 4'h0 || n == 4'hf ||
        ((c % 240) / 16 < int'(m) && c % 16 <= int'(n)))
      return p;
    return ~p;
  endfunction
  function automatic logic [8:0] exp9(logic [7:0] ph, logic p8, int c);
    logic [8:0] e;
    for (int i = 0; i < 8; i++)
      e[i] = lvl(ph[i], global_en ? mni[3:0] : ind[4*i+:4], mni[7:4], c);
    e[8] = lvl(p8, mni[3:0], mni[7:4], c);
    return e;
  endfunction
  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] d;
    rd(LPB_ADDR_PHASE_ZERO, d);
    cmp("ph0 rst", {1'b0, d}, {1'b0, LPB_PHASE_RESET});
    wr(LPB_ADDR_PHASE_ZERO, 8'h5a);
    wr(LPB_ADDR_PHASE_ONE, 8'ha5);
    wr(8'h03, 8'h00);
    rd(LPB_ADDR_PHASE_ZERO, d);
    cmp("ph0", {1'b0, d}, 9'h05a);
    rd(LPB_ADDR_PHASE_ONE, d);
    cmp("ph1", {1'b0, d}, 9'h0a5);
    rd(8'h03, d);
    cmp("unmapped", {1'b0, d}, 9'h000);
  endtask
  // Every row of the phase selection table, PWM parked by master 0
  task automatic t_blink();
    logic [7:0] d;
    logic sel;
    mni = 8'h0f;
    ind = 32'h0123_4567;
    for (int k = 0; k < 8; k++)
    begin
      {blink_en, blink_flip, blink_pin} = 3'(k);
      global_en = k[0];
      n0 = k[0];
      n1 = ~k[0];
      tick();
      tick();
      sel = blink_en && (blink_flip ^ blink_pin);
      cmp("blink", pin, sel ? {n1, 8'ha5} : {n0, 8'h5a});
    end
    rd(LPB_ADDR_PHASE_ZERO, d);
    cmp("rd stored", {1'b0, d}, 9'h05a);
    cmp("drive", {n_out, pout}, 9'h000);
  endtask
  // Sample mid-way through each PWM cycle, on past the frame wrap
  task automatic t_pwm(logic [7:0] mn, logic g, logic [31:0] iv, int steps);
    mni = 8'h00;
    tick();
    tick();
    blink_en = 1'b0;
    global_en = g;
    ind = iv;
    mni = mn;
    repeat (DIV / 2) tick();
    for (int c = 0; c < steps; c++)
    begin
      cmp("pwm", pin, exp9(8'h5a, n0, c));
      repeat (DIV) tick();
    end
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence: two gated slots, then global mode with ninth nibble 2 over full individual nibbles
  initial
  begin
    repeat (6) @(posedge mclk);
    #5;
    cmp("rst pins", pin, LPB_OE_N_RESET);
    cmp("rst rdata", {1'b0, rdata}, {1'b0, LPB_RDATA_RESET});
    rst_n = 1'b1;
    tick();
    t_regs();
    t_blink();
    t_pwm(8'h24, 1'b0, 32'hfe30_e710, 250);
    t_pwm(8'h12, 1'b1, 32'hffff_ffff, 250);
    end_sim();
  end
  // Watchdog, generous against about 5k clocks of traffic
  initial
  begin
    #(20000 * 50);
    miscompares++;
    end_sim();
  end
endmodule
